// ===== rtl/perf_state_request_control.sv
// Purpose: per-core performance-state request, limit and report registers
// Assumes: one instance per core; freq hardware answers each change with freq_done
// Notes: writes to read-only registers raise a one-cycle fault pulse, contents unchanged
`timescale 1ns/1ps
`default_nettype none
module perf_state_request_control
    import perf_state_pkg::*;
#(
    parameter logic [STATE_W-1:0] MAX_INIT = MAX_RESET,
    parameter logic [STATE_W-1:0] FLOOR_INIT = FLOOR_RESET,
    parameter logic [STATE_W-1:0] REQ_INIT = REQ_RESET,
    parameter logic [STATE_W-1:0] ACH_INIT = ACH_RESET
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [MSR_ADDR_W-1:0] msr_addr,
    input wire logic msr_rd,
    input wire logic msr_wr,
    input wire logic [MSR_DATA_W-1:0] msr_wdata,
    output logic [MSR_DATA_W-1:0] msr_rdata,
    output logic msr_hit,
    output logic general_protection_fault,
    input wire logic [STATE_W-1:0] hw_floor,
    output logic [STATE_W-1:0] freq_target,
    output logic freq_req,
    input wire logic freq_done,
    input wire logic [STATE_W-1:0] freq_achieved,
    output logic cap_hw_state_ctrl
);
    typedef enum logic [0:0] {IDLE, CHANGING} chg_e;

    logic [STATE_W-1:0] max_reg;
    logic [STATE_W-1:0] floor_reg;
    logic [STATE_W-1:0] req_reg;
    logic [STATE_W-1:0] ach_reg;
    logic [STATE_W-1:0] target_reg;
    logic [MSR_DATA_W-1:0] rdata_reg;
    logic [MSR_DATA_W-1:0] rdata_next;
    logic fault_reg;
    chg_e state_reg;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire sel_limit = (msr_addr == PERF_STATE_LIMIT_ADDR);
    wire sel_req = (msr_addr == PERF_STATE_REQUEST_ADDR);
    wire sel_rep = (msr_addr == PERF_STATE_REPORT_ADDR);
    wire any_sel = sel_limit | sel_req | sel_rep;
    wire req_wr = msr_wr & sel_req;
    wire ro_wr = msr_wr & (sel_limit | sel_rep);
    wire [STATE_W-1:0] wr_idx = msr_wdata[REQ_LSB +: STATE_W];
    wire [STATE_W-1:0] wr_clipped;
    wire [STATE_W-1:0] new_target;
    wire [STATE_W-1:0] cur_clipped;

    // clip the incoming write, and separately form the target from stored values
    perf_state_target #(.W(STATE_W)) u_wr_clip (
        .request(wr_idx),
        .floor_idx(floor_reg),
        .max_idx(max_reg),
        .clipped(wr_clipped),
        .target()
    );
    perf_state_target #(.W(STATE_W)) u_target (
        .request(req_reg),
        .floor_idx(floor_reg),
        .max_idx(max_reg),
        .clipped(cur_clipped),
        .target(new_target)
    );

    // reserved fields read as zero
    always_comb begin
        rdata_next = '0;
        if (sel_limit) begin
            rdata_next[MAX_LSB +: STATE_W] = max_reg;
            rdata_next[FLOOR_LSB +: STATE_W] = floor_reg;
        end else if (sel_req) begin
            rdata_next[REQ_LSB +: STATE_W] = req_reg;
        end else if (sel_rep) begin
            rdata_next[ACH_LSB +: STATE_W] = ach_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            max_reg <= MAX_INIT;
            floor_reg <= FLOOR_INIT;
            req_reg <= REQ_INIT;
            rdata_reg <= '0;
            fault_reg <= 1'b0;
        end else begin
            floor_reg <= hw_floor;
            fault_reg <= ro_wr;
            if (msr_rd) begin
                rdata_reg <= rdata_next;
            end
            if (req_wr) begin
                req_reg <= wr_clipped;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frequency change sequencing; a new target while changing is issued after done
    wire target_moved = (new_target != target_reg);
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            target_reg <= ACH_INIT;
            ach_reg <= ACH_INIT;
            state_reg <= IDLE;
        end else begin
            unique case (state_reg)
                IDLE: begin
                    if (target_moved) begin
                        target_reg <= new_target;
                        state_reg <= CHANGING;
                    end
                end
                CHANGING: begin
                    if (freq_done) begin
                        ach_reg <= freq_achieved;
                        state_reg <= IDLE;
                    end
                end
            endcase
        end
    end

    assign freq_target = target_reg;
    assign freq_req = (state_reg == CHANGING);
    assign msr_rdata = rdata_reg;
    assign msr_hit = any_sel;
    assign general_protection_fault = fault_reg;
    // one instance per core: nothing is shared between cores here
    assign cap_hw_state_ctrl = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_clip;
        @(posedge sys_clk) disable iff (srst)
        req_wr |=> req_reg == (($past(wr_idx) > $past(max_reg)) ? $past(max_reg) : $past(wr_idx));
    endproperty
    a_clip: assert property (p_clip) else $error("stored request not clipped");

    property p_ro_fault;
        @(posedge sys_clk) disable iff (srst)
        ro_wr |=> general_protection_fault;
    endproperty
    a_ro_fault: assert property (p_ro_fault) else $error("no fault on read-only write");

    property p_no_spurious_fault;
        @(posedge sys_clk) disable iff (srst)
        !ro_wr |=> !general_protection_fault;
    endproperty
    a_no_spurious_fault: assert property (p_no_spurious_fault) else $error("spurious fault");

    property p_req_stable;
        @(posedge sys_clk) disable iff (srst)
        !req_wr |=> $stable(req_reg);
    endproperty
    a_req_stable: assert property (p_req_stable) else $error("request changed without write");

    property p_floor_track;
        @(posedge sys_clk) disable iff (srst)
        1'b1 |=> floor_reg == $past(hw_floor);
    endproperty
    a_floor_track: assert property (p_floor_track) else $error("floor not tracking hardware");

    property p_target_max;
        @(posedge sys_clk) disable iff (srst)
        (state_reg == IDLE && target_moved) |=>
            freq_target >= $past(floor_reg) && freq_target >= $past(cur_clipped);
    endproperty
    a_target_max: assert property (p_target_max) else $error("target not max of request and floor");

    property p_report_hold;
        @(posedge sys_clk) disable iff (srst)
        !(freq_done && state_reg == CHANGING) |=> $stable(ach_reg);
    endproperty
    a_report_hold: assert property (p_report_hold) else $error("report moved without done");

    property p_report_rd;
        @(posedge sys_clk) disable iff (srst)
        (msr_rd && sel_rep) |=> msr_rdata == {{(MSR_DATA_W-STATE_W){1'b0}}, $past(ach_reg)};
    endproperty
    a_report_rd: assert property (p_report_rd) else $error("report read wrong");

    property p_limit_rd;
        @(posedge sys_clk) disable iff (srst)
        (msr_rd && sel_limit) |=> msr_rdata[MSR_DATA_W-1:8] == '0 && msr_rdata[7:4] == $past(max_reg);
    endproperty
    a_limit_rd: assert property (p_limit_rd) else $error("limit read wrong");

    property p_rdata_hold;
        @(posedge sys_clk) disable iff (srst)
        !msr_rd |=> $stable(msr_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

    property p_req_rd;
        @(posedge sys_clk) disable iff (srst)
        (msr_rd && sel_req) |=> msr_rdata == {{(MSR_DATA_W-STATE_W){1'b0}}, $past(req_reg)};
    endproperty
    a_req_rd: assert property (p_req_rd) else $error("request read wrong");

    property p_limit_floor_rd;
        @(posedge sys_clk) disable iff (srst)
        (msr_rd && sel_limit) |=> msr_rdata[3:0] == $past(floor_reg);
    endproperty
    a_limit_floor_rd: assert property (p_limit_floor_rd) else $error("floor read wrong");

    property p_unmapped_rd;
        @(posedge sys_clk) disable iff (srst)
        (msr_rd && !any_sel) |=> msr_rdata == '0;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

    property p_change_holds;
        @(posedge sys_clk) disable iff (srst)
        (freq_req && !freq_done) |=> freq_req && $stable(freq_target);
    endproperty
    a_change_holds: assert property (p_change_holds) else $error("change dropped before done");

    property p_done_drops;
        @(posedge sys_clk) disable iff (srst)
        (freq_req && freq_done) |=> !freq_req;
    endproperty
    a_done_drops: assert property (p_done_drops) else $error("request stayed after done");

    property p_report_take;
        @(posedge sys_clk) disable iff (srst)
        (freq_req && freq_done) |=> ach_reg == $past(freq_achieved);
    endproperty
    a_report_take: assert property (p_report_take) else $error("report missed achieved state");

    property p_issue;
        @(posedge sys_clk) disable iff (srst)
        (!freq_req && target_moved) |=> freq_req;
    endproperty
    a_issue: assert property (p_issue) else $error("moved target not issued");

    property p_no_issue;
        @(posedge sys_clk) disable iff (srst)
        (!freq_req && !target_moved) |=> !freq_req;
    endproperty
    a_no_issue: assert property (p_no_issue) else $error("change issued without new target");

    property p_cap;
        @(posedge sys_clk) disable iff (srst)
        1'b1 |-> cap_hw_state_ctrl;
    endproperty
    a_cap: assert property (p_cap) else $error("capability bit low");

    property p_fault_keeps_req;
        @(posedge sys_clk) disable iff (srst)
        ro_wr |=> $stable(req_reg);
    endproperty
    a_fault_keeps_req: assert property (p_fault_keeps_req) else $error("faulting write changed request");

    property p_cov_change;
        @(posedge sys_clk) disable iff (srst)
        req_wr ##[1:20] (freq_done && state_reg == CHANGING);
    endproperty
    c_change: cover property (p_cov_change);

    property p_cov_clip;
        @(posedge sys_clk) disable iff (srst)
        req_wr && wr_idx > max_reg;
    endproperty
    c_clip: cover property (p_cov_clip);

    property p_cov_fault;
        @(posedge sys_clk) disable iff (srst)
        ro_wr;
    endproperty
    c_fault: cover property (p_cov_fault);

    property p_cov_late_target;
        @(posedge sys_clk) disable iff (srst)
        freq_req && target_moved;
    endproperty
    c_late_target: cover property (p_cov_late_target);

    property p_cov_unmapped;
        @(posedge sys_clk) disable iff (srst)
        msr_wr && !any_sel;
    endproperty
    c_unmapped: cover property (p_cov_unmapped);
endmodule
`default_nettype wire

// ===== common/perf_state_pkg.sv
// Purpose: shared constants for the per-core performance-state request block
// Assumes: registers reached by a model-specific register port (address, read, write strobes)
// Notes: reset values of the four state fields are module parameters of the top
package perf_state_pkg;
    localparam int unsigned STATE_W = 4;
    localparam int unsigned NUM_STATES = 16;
    localparam int unsigned MSR_ADDR_W = 32;
    localparam int unsigned MSR_DATA_W = 64;
    localparam logic [31:0] PERF_STATE_LIMIT_ADDR = 32'hc0010061;
    localparam logic [31:0] PERF_STATE_REQUEST_ADDR = 32'hc0010062;
    localparam logic [31:0] PERF_STATE_REPORT_ADDR = 32'hc0010063;
    localparam int unsigned FLOOR_LSB = 0;
    localparam int unsigned MAX_LSB = 4;
    localparam int unsigned REQ_LSB = 0;
    localparam int unsigned ACH_LSB = 0;
    localparam int unsigned CAP_HW_STATE_BIT = 7;
    localparam logic [3:0] MAX_RESET = 4'hf;
    localparam logic [3:0] FLOOR_RESET = 4'h0;
    localparam logic [3:0] REQ_RESET = 4'h0;
    localparam logic [3:0] ACH_RESET = 4'h0;
endpackage

// ===== rtl/perf_state_target.sv
// Purpose: combine a clipped software request with the hardware floor into the effective state
// Assumes: all inputs synchronous to sys_clk
// Notes: purely combinational helper
`timescale 1ns/1ps
`default_nettype none
module perf_state_target
    import perf_state_pkg::*;
#(
    parameter int unsigned W = STATE_W
) (
    input wire logic [W-1:0] request,
    input wire logic [W-1:0] floor_idx,
    input wire logic [W-1:0] max_idx,
    output logic [W-1:0] clipped,
    output logic [W-1:0] target
);
    // larger index is the slower state; the floor forbids anything faster
    assign clipped = (request > max_idx) ? max_idx : request;
    assign target = (clipped > floor_idx) ? clipped : floor_idx;
endmodule
`default_nettype wire

// ===== sim/perf_state_request_control_tb.sv
// Purpose: self-checking bench for the per-core performance-state request block
// Assumes: bench drives every input at the falling edge of sys_clk
// Notes: maximum index lowered to 4'hc so that clipping of a request is visible
`timescale 1ns/1ps
`default_nettype none
module perf_state_request_control_tb;
    import perf_state_pkg::*;
    localparam logic [3:0] MAXV = 4'hc;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [31:0] msr_addr = 32'h0;
    logic msr_rd = 1'b0;
    logic msr_wr = 1'b0;
    logic [63:0] msr_wdata = 64'h0;
    logic [63:0] msr_rdata;
    logic msr_hit;
    logic general_protection_fault;
    logic [3:0] hw_floor = 4'h0;
    logic [3:0] freq_target;
    logic freq_req;
    logic freq_done = 1'b0;
    logic [3:0] freq_achieved = 4'h0;
    logic cap_hw_state_ctrl;
    int miscompares = 0;
    int num_checks = 0;
    logic flt;
    // rows: written word, hardware floor, stored request, effective target
    logic [63:0] wd [6] = '{64'h3, 64'hffff_ffff_ffff_fff5, 64'he, 64'h1, 64'h9, 64'h0};
    logic [3:0] fl [6] = '{4'h0, 4'h7, 4'h2, 4'h0, 4'hf, 4'h0};
    logic [3:0] rq [6] = '{4'h3, 4'h5, 4'hc, 4'h1, 4'h9, 4'h0};
    logic [3:0] tg [6] = '{4'h3, 4'h7, 4'hc, 4'h1, 4'hf, 4'h0};

    perf_state_request_control #(.MAX_INIT(MAXV)) dut (.sys_clk(sys_clk), .srst(srst), .msr_addr(msr_addr),
        .msr_rd(msr_rd), .msr_wr(msr_wr), .msr_wdata(msr_wdata), .msr_rdata(msr_rdata), .msr_hit(msr_hit),
        .general_protection_fault(general_protection_fault), .hw_floor(hw_floor), .freq_target(freq_target),
        .freq_req(freq_req), .freq_done(freq_done), .freq_achieved(freq_achieved),
        .cap_hw_state_ctrl(cap_hw_state_ctrl));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // a strobe always has one idle edge before it, so no signal is set twice in one step
    task automatic wr(input logic [31:0] a, input logic [63:0] d, input logic [3:0] f, output logic fault);
        @(negedge sys_clk);
        msr_addr = a;
        msr_wdata = d;
        hw_floor = f;
        msr_wr = 1'b1;
        @(negedge sys_clk);
        msr_wr = 1'b0;
        fault = general_protection_fault;
    endtask

    task automatic rd(input logic [31:0] a, input logic [63:0] exp);
        @(negedge sys_clk);
        msr_addr = a;
        msr_rd = 1'b1;
        @(negedge sys_clk);
        msr_rd = 1'b0;
        chk(msr_rdata, exp);
    endtask

    task automatic wait_req();
        int n;
        n = 0;
        while (freq_req !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        chk(freq_req, 1'b1);
    endtask

    task automatic finish_change(input logic [3:0] ach);
        @(negedge sys_clk);
        freq_achieved = ach;
        freq_done = 1'b1;
        @(negedge sys_clk);
        freq_done = 1'b0;
        chk(freq_req, 1'b0);
    endtask

    task automatic rst_chk();
        chk(freq_req, 1'b0);
        chk(freq_target, 4'h0);
        rd(PERF_STATE_REQUEST_ADDR, 64'h0);
        rd(PERF_STATE_REPORT_ADDR, 64'h0);
        rd(PERF_STATE_LIMIT_ADDR, {56'h0, MAXV, 4'h0});
        chk(cap_hw_state_ctrl, 1'b1);
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        miscompares++;
        give_verdict();
    end

    initial begin
        repeat (16) @(negedge sys_clk);
        srst = 1'b0;
        rst_chk();
        for (int i = 0; i < 6; i++) begin
            wr(PERF_STATE_REQUEST_ADDR, wd[i], fl[i], flt);
            chk(flt, 1'b0);
            rd(PERF_STATE_REQUEST_ADDR, {60'h0, rq[i]});
            chk(msr_hit, 1'b1);
            rd(PERF_STATE_LIMIT_ADDR, {56'h0, MAXV, fl[i]});
            wait_req();
            chk(freq_target, tg[i]);
            rd(PERF_STATE_REPORT_ADDR, {60'h0, (i == 0) ? 4'h0 : tg[i-1]});
            finish_change(tg[i]);
            rd(PERF_STATE_REPORT_ADDR, {60'h0, tg[i]});
        end
        // achieved state differs from the request when another core holds it back
        wr(PERF_STATE_REQUEST_ADDR, 64'h5, 4'h0, flt);
        wait_req();
        finish_change(4'h8);
        rd(PERF_STATE_REPORT_ADDR, 64'h8);
        wr(PERF_STATE_LIMIT_ADDR, 64'hff, 4'h0, flt);
        chk(flt, 1'b1);
        rd(PERF_STATE_LIMIT_ADDR, {56'h0, MAXV, 4'h0});
        wr(PERF_STATE_REPORT_ADDR, 64'h3, 4'h0, flt);
        chk(flt, 1'b1);
        rd(PERF_STATE_REPORT_ADDR, 64'h8);
        wr(32'hc0010064, 64'h7, 4'h0, flt);
        chk(flt, 1'b0);
        rd(32'hc0010064, 64'h0);
        chk(msr_hit, 1'b0);
        // reset lands in the middle of an outstanding change
        wr(PERF_STATE_REQUEST_ADDR, 64'h6, 4'h0, flt);
        wait_req();
        srst = 1'b1;
        repeat (2) @(negedge sys_clk);
        srst = 1'b0;
        rst_chk();
        give_verdict();
    end
endmodule
`default_nettype wire
